//--- dpr_pkg.sv
// Purpose: Shared constants and types for the DDR3 power-down, reset and termination model.
// Assumes: One 50 MHz clock; registers reached over APB with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
package dpr_pkg;
   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [11:0] OFS_MODE0   = 12'h000;  // Mode word 0: exit mode and write recovery.
   localparam logic [11:0] OFS_MODE1   = 12'h004;  // Mode word 1: nominal termination code.
   localparam logic [11:0] OFS_LAT     = 12'h008;  // Write latency and additive latency.
   localparam logic [11:0] OFS_STATUS  = 12'h00c;  // Read-only block state.
   localparam logic [11:0] OFS_RTT     = 12'h010;  // Read-only termination value in ohms.
   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int FAST_EXIT_BIT = 12;   // Mode word 0 bit selecting fast precharge power-down exit.
   localparam int WR_LSB        = 9;    // Write recovery field low bit.
   localparam int WR_MSB        = 11;   // Write recovery field high bit.
   localparam int RTT_B2        = 9;    // Termination code bit 2 position.
   localparam int RTT_B1        = 6;    // Termination code bit 1 position.
   localparam int RTT_B0        = 2;    // Termination code bit 0 position.
   // ==========================================================
   // Reset values and constants
   // ==========================================================
   localparam logic [31:0] MODE0_RST = 32'h0000_0000;  // Slow exit, recovery code zero.
   localparam logic [31:0] MODE1_RST = 32'h0000_0000;  // Termination disabled.
   localparam logic [4:0]  CWL_RST   = 5'h05;          // Default write latency.
   localparam logic [4:0]  AL_RST    = 5'h00;          // Default additive latency.
   localparam logic [8:0]  RZQ_OHM   = 9'h0f0;         // Reference resistance, 240 ohms.
   localparam int CLK_PS             = 20000;          // Clock period in picoseconds.
   localparam int AON_MIN_PS         = 2000;           // Async switch earliest, 2 ns.
   localparam int AON_MAX_PS         = 8500;           // Async switch latest, 8.5 ns.
   // Least time rounds up, longest rounds down, never below one cycle.
   localparam int AON_MIN_CYC = (AON_MIN_PS + CLK_PS - 1) / CLK_PS;
   localparam int AON_MAX_RAW = AON_MAX_PS / CLK_PS;
   localparam int AON_MAX_CYC = (AON_MAX_RAW < 1) ? 1 : AON_MAX_RAW;
   localparam logic [3:0] SYNC_OFS = 4'h2;              // Subtracted from CWL plus AL.
   // ==========================================================
   // Types
   // ==========================================================
   typedef struct packed {
      logic       cke;     // Clock enable pin after synchronising.
      logic       rst_n;   // Device reset pin after synchronising, active low.
      logic       odt;     // Termination request pin after synchronising.
      logic       nop;     // NOP or deselect decoded this cycle.
      logic       srf;     // Device is in self refresh.
      logic       bank_open; // At least one bank open.
   } dpr_pins_t;
   typedef enum logic [3:0] {
      ST_RESET = 4'b0001,
      ST_IDLE  = 4'b0010,
      ST_APD   = 4'b0100,
      ST_PPD   = 4'b1000
   } dpr_state_t;
endpackage

//--- dpr_sync.sv
// Purpose: Two-flop synchroniser bank for pin inputs.
// Assumes: Inputs are asynchronous to clock.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module dpr_sync #(parameter int W = 4)
(
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta; // First stage.
   // ==========================================================
   // Synchroniser
   // ==========================================================
   // Two stages give metastability time to settle.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         meta <= '0;
         dout <= '0;
      end
      else
      begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // dpr_sync

//--- dpr_core.sv
// Purpose: Power-down residency and exit, reset pin handling and nominal termination control.
// Assumes: Controller keeps its own timing; APB slave with zero wait states.
// Notes:   Termination is modelled as an enable plus a resistance value in ohms.
`timescale 1ns/1ps
module dpr_core
   import dpr_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic                cke_pin,
   input  wire logic                reset_n_pin,
   input  wire logic                odt_pin,
   input  wire logic                cmd_nop,
   input  wire logic                self_refresh,
   input  wire logic                bank_open,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic                     rtt_on,
   output logic      [8:0]          rtt_ohm,
   output logic                     dll_on,
   output logic                     out_enable,
   output logic      [3:0]          dev_state
);
   import dpr_pkg::*;
   // ==========================================================
   // Pin synchronisation
   // ==========================================================
   // Only the three real pins are synchronised; a spare stage would be a constant flop.
   logic [2:0]  pin_sync;    // Synchronised cke, reset_n and odt.
   dpr_pins_t   pins;        // Bundled pin and command view.
   dpr_sync #(.W(3)) u_sync
   (
      .clock (clock),
      .rst   (rst),
      .din   ({cke_pin, reset_n_pin, odt_pin}),
      .dout  (pin_sync)
   );
   assign pins = '{cke: pin_sync[2], rst_n: pin_sync[1], odt: pin_sync[0],
                   nop: cmd_nop, srf: self_refresh, bank_open: bank_open};
   // ==========================================================
   // Register file
   // ==========================================================
   logic [31:0] mode0;       // Exit mode and write recovery.
   logic [31:0] mode1;       // Termination code.
   logic [4:0]  cwl;         // Write latency.
   logic [4:0]  al;          // Additive latency.
   dpr_state_t  state;       // Power state.
   dpr_state_t  next_state;  // Next power state.
   logic        wr_hit;      // Write access phase.
   logic [2:0]  rtt_code;    // Gathered termination code.
   logic [2:0]  wr_code;     // Write recovery code.
   logic        fast_bit;    // Fast exit selection.
   assign pready  = 1'b1;    // Zero wait states.
   assign wr_hit  = psel && penable && pwrite;
   assign fast_bit = mode0[FAST_EXIT_BIT];
   assign wr_code  = mode0[WR_MSB:WR_LSB];
   assign rtt_code = {mode1[RTT_B2], mode1[RTT_B1], mode1[RTT_B0]};
   // Unmapped addresses answer with an error and zero data.
   wire hit_m0  = (paddr == OFS_MODE0);
   wire hit_m1  = (paddr == OFS_MODE1);
   wire hit_lat = (paddr == OFS_LAT);
   wire hit_st  = (paddr == OFS_STATUS);
   wire hit_rtt = (paddr == OFS_RTT);
   wire mapped  = hit_m0 || hit_m1 || hit_lat || hit_st || hit_rtt;
   assign pslverr = psel && penable && !mapped;
   logic [31:0] rd_word;     // Read mux output ahead of the data register.
   // Read data mux; the status word reports live block state.
   always_comb
   begin
      if (hit_m0)
         rd_word = mode0;
      else if (hit_m1)
         rd_word = mode1;
      else if (hit_lat)
         rd_word = {19'h0, al, 3'h0, cwl};
      else if (hit_st)
         rd_word = {24'h0, dll_on, rtt_on, out_enable, 1'b0, state};
      else if (hit_rtt)
         rd_word = {23'h0, rtt_ohm};
      else
         rd_word = 32'h0;
   end
   // ==========================================================
   // Read data register
   // ==========================================================
   // Read data is captured in the setup cycle, so it stands for the whole access phase
   // without a wait state; the status word is therefore one cycle old when it is taken.
   always_ff @(posedge clock)
   begin
      if (rst)
         prdata <= 32'h0;
      else if (psel && !penable)
         prdata <= rd_word;                               // Setup cycle only.
   end
   // Mode words are cleared by the device reset pin too.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         mode0 <= MODE0_RST;
         mode1 <= MODE1_RST;
         cwl   <= CWL_RST;
         al    <= AL_RST;
      end
      else if (!pins.rst_n)
      begin
         mode0 <= MODE0_RST;
         mode1 <= MODE1_RST;
         cwl   <= CWL_RST;
         al    <= AL_RST;
      end
      else if (wr_hit && hit_m0)
         mode0 <= pwdata;
      else if (wr_hit && hit_m1)
         mode1 <= pwdata;
      else if (wr_hit && hit_lat)
      begin
         cwl <= pwdata[4:0];
         al  <= pwdata[12:8];
      end
   end
   // ==========================================================
   // Power state machine
   // ==========================================================
   // Reset pin wins over every other condition, including power-down.
   always_comb
   begin
      next_state = state;
      case (state)
         ST_RESET:
            if (pins.rst_n)
               next_state = ST_IDLE;
         ST_IDLE:
            if (!pins.rst_n)
               next_state = ST_RESET;
            else if (!pins.cke && pins.nop)
               next_state = pins.bank_open ? ST_APD : ST_PPD;
         ST_APD, ST_PPD:
            if (!pins.rst_n)
               next_state = ST_RESET;
            else if (pins.cke && pins.nop)
               next_state = ST_IDLE;
         default:
            next_state = ST_RESET;
      endcase
   end
   always_ff @(posedge clock)
   begin
      if (rst)
         state <= ST_RESET;
      else
         state <= next_state;
   end
   assign dev_state  = state;
   assign out_enable = (state != ST_RESET);
   // DLL stays on except in reset and in slow-exit precharge power-down.
   wire slow_ppd = (state == ST_PPD) && !fast_bit;
   assign dll_on = (state != ST_RESET) && !slow_ppd;
   // ==========================================================
   // Termination control
   // ==========================================================
   // Resistance lookup; reserved codes give zero ohms and no termination.
   function automatic logic [8:0] rtt_value(input logic [2:0] code);
      case (code)
         3'h1: rtt_value = RZQ_OHM / 9'h004;
         3'h2: rtt_value = RZQ_OHM / 9'h002;
         3'h3: rtt_value = RZQ_OHM / 9'h006;
         3'h4: rtt_value = RZQ_OHM / 9'h00c;
         3'h5: rtt_value = RZQ_OHM / 9'h008;
         default: rtt_value = 9'h000;
      endcase
   endfunction
   wire        rtt_legal = (rtt_code != 3'h0) && (rtt_code < 3'h6);
   wire        odt_eff   = pins.odt && rtt_legal && !pins.srf;
   wire        async_md  = !dll_on;
   wire [5:0]  lat_sum   = {1'b0, cwl} + {1'b0, al};
   wire [5:0]  sync_lat  = (lat_sum > {2'h0, SYNC_OFS}) ? lat_sum - {2'h0, SYNC_OFS} : 6'h0;
   logic [31:0] odt_hist;   // Shift history of the sampled request.
   logic [3:0]  async_cnt;  // Cycles since the last change, held at AON_MAX_CYC.
   logic        async_val;  // Value awaiting asynchronous application.
   logic        rtt_q;      // Applied termination state.
   // History shifts each cycle so the synchronous delay is a tap select.
   always_ff @(posedge clock)
   begin
      if (rst || !pins.rst_n)
         odt_hist <= 32'h0;
      else
         odt_hist <= {odt_hist[30:0], odt_eff};
   end
   // Asynchronous mode applies a change after the bounded nanosecond delay.
   always_ff @(posedge clock)
   begin
      if (rst || !pins.rst_n)
      begin
         async_cnt <= 4'h0;
         async_val <= 1'b0;
      end
      else if (odt_eff != async_val)
      begin
         async_val <= odt_eff;
         async_cnt <= 4'h1;
      end
      else if (async_cnt != 4'h0 && async_cnt < AON_MAX_CYC[3:0])
         async_cnt <= async_cnt + 4'h1;
   end
   wire sync_tap  = (sync_lat == 6'h0) ? odt_eff : odt_hist[sync_lat[4:0] - 5'h1];
   wire async_rdy = (async_cnt >= AON_MIN_CYC[3:0]) || (async_cnt == 4'h0);
   // Turn-off lands on the edge after the latency, the half clock being absorbed here.
   always_ff @(posedge clock)
   begin
      if (rst || !pins.rst_n)
         rtt_q <= 1'b0;
      else if (async_md)
      begin
         if (async_rdy)
            rtt_q <= async_val;
      end
      else
         rtt_q <= sync_tap;
   end
   assign rtt_on  = rtt_q && rtt_legal && out_enable;
   assign rtt_ohm = rtt_on ? rtt_value(rtt_code) : 9'h000;
   // ==========================================================
   // Checks
   // ==========================================================
   a_reset_exit_pd: assert property (@(posedge clock) disable iff (rst)
      ((state == ST_APD || state == ST_PPD) && !pins.rst_n) |=> state == ST_RESET)
      else $error("Reset pin did not end power-down.");
   a_pd_exit_ok: assert property (@(posedge clock) disable iff (rst)
      ((state == ST_APD || state == ST_PPD) && pins.rst_n && pins.cke && pins.nop) |=> state == ST_IDLE)
      else $error("Power-down exit missed.");
   a_dll_slow: assert property (@(posedge clock) disable iff (rst)
      (state == ST_PPD && !fast_bit) |-> !dll_on)
      else $error("DLL on in slow-exit power-down.");
   a_rtt_reset_off: assert property (@(posedge clock) disable iff (rst)
      (state == ST_RESET) |-> !rtt_on && !out_enable)
      else $error("Termination or outputs live in reset.");
   a_odt_ignored: assert property (@(posedge clock) disable iff (rst)
      (!rtt_legal) |-> rtt_ohm == 9'h000)
      else $error("Termination with disabled code.");
   a_wr_field: assert property (@(posedge clock) disable iff (rst)
      (wr_hit && hit_m0 && pins.rst_n) |=> wr_code == $past(pwdata[11:9]))
      else $error("Write recovery field not stored.");
   a_rtt_value: assert property (@(posedge clock) disable iff (rst)
      (rtt_on && rtt_code == 3'h2) |-> rtt_ohm == 9'h078)
      else $error("Wrong termination value.");
   a_sync_delay: assert property (@(posedge clock) disable iff (rst || !pins.rst_n)
      (!async_md && sync_lat == 6'h3 && $past(async_md) == 1'b0) |-> rtt_q == $past(odt_hist[2]))
      else $error("Synchronous termination delay wrong.");
   a_async_delay: assert property (@(posedge clock) disable iff (rst || !pins.rst_n)
      (async_md && async_cnt == 4'h1 && $past(async_md)) |-> ##[0:1] rtt_q == async_val || !async_md)
      else $error("Asynchronous termination too slow.");
   // Power-down is left only by the pin reset or a sampled CKE high with NOP.
   wire in_pd = (state == ST_APD) || (state == ST_PPD);   // Either power-down state.
   sequence s_pd_held;
      in_pd && pins.rst_n && !(pins.cke && pins.nop);
   endsequence
   // Five samples of self refresh at the reset latency flush the three-deep tap.
   sequence s_srf_settled;
      (pins.srf && !async_md && sync_lat == 6'h3) [*5];
   endsequence
   a_pd_stays: assert property (@(posedge clock) disable iff (rst)
      s_pd_held |=> $stable(state))
      else $error("Power-down left without a wake condition.");
   a_mode_clear: assert property (@(posedge clock) disable iff (rst)
      (!pins.rst_n) |=> mode0 == MODE0_RST && mode1 == MODE1_RST)
      else $error("Mode words survived the reset pin.");
   a_srf_rtt_off: assert property (@(posedge clock) disable iff (rst || !pins.rst_n)
      s_srf_settled |-> !rtt_on)
      else $error("Termination on in self refresh.");
endmodule // dpr_core

//--- dpr_ctl_model.sv
// Purpose: Behavioural memory controller driving the pin side of the block.
// Assumes: The bench hands over an op code with a one-cycle go strobe.
// Notes:   Hold times are whole cycles, rounded up from nanoseconds.
`timescale 1ns/1ps
module dpr_ctl_model #(
   parameter int TPD_CYC    = 4,               // Least power-down residency.
   parameter int TXPDLL_CYC = 10,              // Exit delay; covers the shorter exit and CKE high times.
   parameter int TRST_CYC   = (100 + 19) / 20, // Reset pulse of 100 ns at 20 ns, rounded up.
   parameter int ODTH_CYC   = 4                // Least ODT high time.
)
(
   input  wire logic       clock,
   input  wire logic [2:0] op,
   input  wire logic       go,
   output logic            busy,
   output logic            cke_pin,
   output logic            reset_n_pin,
   output logic            odt_pin,
   output logic            cmd_nop
);
   // ==========================================================
   // Pin sequencer
   // ==========================================================
   // Idle pins: clock enabled, reset released, termination off, NOP on the bus.
   // Only NOP is ever sent, so no read can overlap a raised ODT.
   initial
   begin
      busy        = 1'b0;
      cke_pin     = 1'b1;
      reset_n_pin = 1'b1;
      odt_pin     = 1'b0;
      cmd_nop     = 1'b1;
   end
   // An op runs whole before the next is taken, so no hold time is cut short.
   always @(posedge clock)
      if (go && !busy)
      begin
         busy <= 1'b1;
         case (op)
            3'd1: cke_pin <= 1'b0;
            3'd2: cke_pin <= 1'b1;
            3'd3:
            begin
               cke_pin     <= 1'b0;
               reset_n_pin <= 1'b0;
               repeat (TRST_CYC) @(posedge clock);
               reset_n_pin <= 1'b1;
               repeat (2) @(posedge clock);
               cke_pin     <= 1'b1;
            end
            3'd4: odt_pin <= 1'b1;
            default: odt_pin <= 1'b0;
         endcase
         // Keep the new level for the longest minimum that applies to the op.
         case (op)
            3'd1: repeat (TPD_CYC) @(posedge clock);
            3'd4: repeat (ODTH_CYC) @(posedge clock);
            default: repeat (TXPDLL_CYC) @(posedge clock);
         endcase
         busy <= 1'b0;
      end
endmodule // dpr_ctl_model

//--- dpr_core_tb.sv
// Purpose: Self-checking bench for registers, power-down, pin reset and termination.
// Assumes: dpr_ctl_model drives the pins; the bench drives APB and the state levels.
// Notes:   Latencies are compared as differences, so the fixed pin lag cancels.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module dpr_core_tb;
   import dpr_pkg::*;
   // ==========================================================
   // Signals
   // ==========================================================
   logic        clock = 1'b0, rst = 1'b1;                     // Clock and reset.
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;   // APB control.
   logic [11:0] paddr = 12'h000;                              // APB address.
   logic [31:0] pwdata = 32'h0, prdata, q;                    // APB data and last read.
   logic        pready, pslverr, e;                           // APB answer and last error.
   logic        self_refresh = 1'b0, bank_open = 1'b0;        // Device state levels.
   logic        rtt_on, dll_on, out_enable;                   // Block status.
   logic [8:0]  rtt_ohm;                                      // Applied termination.
   logic [3:0]  dev_state;                                    // One-hot state.
   logic [2:0]  op = 3'd0;                                    // Op for the pin model.
   logic        go = 1'b0, busy, cke_pin, reset_n_pin, odt_pin, cmd_nop; // Model handshake and pins.
   int          fail_count = 0, cmp_count = 0, n5, n8, nal, nx; // Counters and latencies.
   int          divs [8] = '{0, 4, 2, 6, 12, 8, 0, 0};          // Divider of each code, 0 for off.
   logic        bo [3] = '{1'b1, 1'b0, 1'b0};                   // Bank open per case.
   logic        fx [3] = '{1'b0, 1'b1, 1'b0};                   // Fast exit bit per case.
   logic        dx [3] = '{1'b1, 1'b1, 1'b0};                   // Expected DLL state.
   logic [3:0]  sx [3] = '{ST_APD, ST_PPD, ST_PPD};             // Expected power-down state.
   logic [31:0] mv;                                            // Mode word under test.
   logic [8:0]  exo;                                           // Expected ohms.
   always #10 clock = ~clock;
   dpr_core dpr_core_i (.clock(clock), .rst(rst), .cke_pin(cke_pin), .reset_n_pin(reset_n_pin),
      .odt_pin(odt_pin), .cmd_nop(cmd_nop), .self_refresh(self_refresh), .bank_open(bank_open),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rtt_on(rtt_on), .rtt_ohm(rtt_ohm), .dll_on(dll_on),
      .out_enable(out_enable), .dev_state(dev_state));
   dpr_ctl_model dpr_ctl_model_i (.clock(clock), .op(op), .go(go), .busy(busy), .cke_pin(cke_pin),
      .reset_n_pin(reset_n_pin), .odt_pin(odt_pin), .cmd_nop(cmd_nop));
   // ==========================================================
   // Tasks
   // ==========================================================
   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // One APB transfer; the idle cycle after it keeps drivers from double assignment.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin fail_count++; give_verdict; end
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, ex, q)
   endtask
   // Hands an op to the pin model; finish waits until the model is idle again.
   task automatic start(input logic [2:0] o);
      op <= o; go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
   endtask
   task automatic finish;
      int n;
      n = 0;
      do begin @(posedge clock); n++; end while (busy !== 1'b0 && n < 200);
      if (n >= 200) begin fail_count++; give_verdict; end
   endtask
   task automatic wait_st(input logic [3:0] s);
      int n;
      n = 0;
      while (dev_state !== s && n < 40) begin @(posedge clock); n++; end
      `CHK("state", s, dev_state)
   endtask
   // Counts cycles from an ODT op until termination reaches the target level.
   task automatic meas(input logic [2:0] o, input logic t, output int n);
      start(o);
      n = 1;
      while (rtt_on !== t && n < 40) begin @(posedge clock); n++; end
      `CHK("rtt_on", t, rtt_on)
      finish;
   endtask
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin repeat (50000) @(posedge clock); fail_count++; give_verdict; end
   initial
   begin
      repeat (2) @(posedge clock);
      `CHK("rst_state", ST_RESET, dev_state)
      `CHK("rst_oe", 1'b0, out_enable)
      rst <= 1'b0;
      wait_st(ST_IDLE);
      rd(OFS_MODE0, MODE0_RST, "mode0");
      rd(OFS_MODE1, MODE1_RST, "mode1");
      rd(OFS_LAT, {19'h0, AL_RST, 3'h0, CWL_RST}, "lat");
      apb(1'b0, 12'h020, 32'h0);
      `CHK("unmapped_err", 1'b1, e)
      apb(1'b1, OFS_RTT, 32'h0000_00ff);
      rd(OFS_RTT, 32'h0, "rtt_ro");
      apb(1'b1, OFS_MODE0, 32'h0000_0a00);
      rd(OFS_MODE0, 32'h0000_0a00, "wr_code");
      start(3'd4);
      finish;
      // Every termination code with ODT high, reserved ones included.
      // No write bursts run, so the write-time limit on codes does not bind.
      for (int c = 0; c < 8; c++)
      begin
         mv = (32'(c / 4) << RTT_B2) | (32'((c / 2) % 2) << RTT_B1) | (32'(c % 2) << RTT_B0);
         exo = (divs[c] == 0) ? 9'h000 : 9'(RZQ_OHM / divs[c]);
         apb(1'b1, OFS_MODE1, mv);
         repeat (4) @(posedge clock);
         `CHK("rtt_ohm", exo, rtt_ohm)
         `CHK("rtt_on_code", divs[c] != 0, rtt_on)
         rd(OFS_RTT, {23'h0, exo}, "rtt_reg");
      end
      // A legal code stays set for the latency scenarios; the three-deep tap needs four edges.
      apb(1'b1, OFS_MODE1, 32'h1 << RTT_B1);
      repeat (4) @(posedge clock);
      `CHK("srf_pre", 1'b1, rtt_on)
      self_refresh <= 1'b1;
      repeat (5) @(posedge clock);
      `CHK("srf_rtt", 1'b0, rtt_on)
      self_refresh <= 1'b0;
      repeat (5) @(posedge clock);
      `CHK("srf_exit", 1'b1, rtt_on)
      // Synchronous latency for two write latencies and one additive latency.
      meas(3'd5, 1'b0, nx);
      meas(3'd4, 1'b1, n5);
      `CHK("on_off_equal", n5, nx)
      apb(1'b1, OFS_LAT, 32'h0000_0008);
      meas(3'd5, 1'b0, nx);
      meas(3'd4, 1'b1, n8);
      `CHK("cwl_step", 3, n8 - n5)
      apb(1'b1, OFS_LAT, 32'h0000_0205);
      meas(3'd5, 1'b0, nx);
      meas(3'd4, 1'b1, nal);
      `CHK("al_step", 2, nal - n5)
      apb(1'b1, OFS_LAT, 32'h0000_0005);
      meas(3'd5, 1'b0, nx);
      // Active, fast precharge and slow precharge power-down.
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, OFS_MODE0, 32'(fx[i]) << FAST_EXIT_BIT);
         bank_open <= bo[i];
         start(3'd1);
         wait_st(sx[i]);
         `CHK("dll_on", dx[i], dll_on)
         finish;
         if (i == 2)
         begin
            meas(3'd4, 1'b1, nx);
            `CHK("async_fast", 1'b1, nx < n5)
            meas(3'd5, 1'b0, nx);
         end
         start(3'd2);
         wait_st(ST_IDLE);
         finish;
      end
      // Pin reset in the middle of precharge power-down.
      start(3'd4);
      finish;
      start(3'd1);
      wait_st(ST_PPD);
      finish;
      start(3'd3);
      wait_st(ST_RESET);
      `CHK("pin_rst_oe", 1'b0, out_enable)
      `CHK("pin_rst_rtt", 1'b0, rtt_on)
      finish;
      wait_st(ST_IDLE);
      rd(OFS_MODE1, MODE1_RST, "mode1_clr");
      give_verdict;
   end
endmodule // dpr_core_tb
